// ---- src/external_request_flags.sv ----
// request flags for six external request lines, reached over ahb-lite
// assumes zero-wait single word transfers; accept strobe comes from the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ext_req_defs.svh"

// Operation
// - each of request lines 0 to 5 has a flag at bit n of the flag register, read and written by software.
// - every flag is 0 after reset.
// - in level mode a flag reads 1 while its pin is low.
// - in level mode a flag reads 0 while its pin is high, and writes do not touch it.
// - in edge mode the selected pin edge sets the flag, which stays set until cleared.
// - in edge mode software clears a flag by reading it as 1 and then writing 0.
// - in edge mode a flag clears when the processor accepts that line's interrupt.
module external_request_flags
    import ext_req_pkg::*;
#(
    parameter int LINES = `EXT_REQ_LINES
)(
    input  wire logic               clock,        // system clock, 40 MHz
    input  wire logic               rstn,         // synchronous reset, active low
    input  wire logic [LINES-1:0]   ext_req_pin,  // request pins, active low
    input  wire logic               accept_valid, // processor accepts an interrupt
    input  wire logic [2:0]         accept_line,  // line being accepted
    output logic [LINES-1:0]        ext_req_out,  // request flags to the priority logic
    input  wire logic               hsel,         // ahb slave select
    input  wire logic [31:0]        haddr,        // ahb address
    input  wire logic [1:0]         htrans,       // ahb transfer type
    input  wire logic               hwrite,       // ahb write
    input  wire logic [2:0]         hsize,        // ahb size
    input  wire logic [31:0]        hwdata,       // ahb write data
    input  wire logic               hready,       // ahb ready in
    output logic [31:0]             hrdata,       // ahb read data
    output logic                    hreadyout,    // ahb ready out
    output logic                    hresp         // ahb response
);

    ahb_aphase_s      aphase_q;
    logic [LINES-1:0] mode_q;
    logic [LINES-1:0] rising_q;
    logic [LINES-1:0] flag;
    logic [LINES-1:0] pin_level;
    logic [LINES-1:0] accept_vec;
    logic [LINES-1:0] ext_req_out_q;
    logic [31:0]      hrdata_q;
    logic             hreadyout_q;
    logic             hresp_q;
    logic             take;
    logic             rd_flag;
    logic             wr_flag;
    reg_sel_e         rd_sel;
    reg_sel_e         wr_sel;

    // a new transfer is taken on an active select with the bus ready
    assign take = hsel & hready & (htrans == `EXT_REQ_HTRANS_NONSEQ || htrans == `EXT_REQ_HTRANS_SEQ);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            aphase_q <= '0;
        end else if (hready) begin
            aphase_q.valid <= take & hwrite;
            aphase_q.write <= hwrite;
            aphase_q.addr  <= haddr[`EXT_REQ_ADDR_W-1:0];
        end
    end

    // decode of the address being read now
    always_comb begin
        if (haddr[`EXT_REQ_ADDR_W-1:0] == `EXT_REQ_FLAG_OFS) begin
            rd_sel = SEL_FLAG;
        end else if (haddr[`EXT_REQ_ADDR_W-1:0] == `EXT_REQ_MODE_OFS) begin
            rd_sel = SEL_MODE;
        end else if (haddr[`EXT_REQ_ADDR_W-1:0] == `EXT_REQ_EDGE_OFS) begin
            rd_sel = SEL_EDGE;
        end else if (haddr[`EXT_REQ_ADDR_W-1:0] == `EXT_REQ_PIN_OFS) begin
            rd_sel = SEL_PIN;
        end else begin
            rd_sel = SEL_NONE;
        end
        if (haddr[31:`EXT_REQ_ADDR_W] != '0) begin
            rd_sel = SEL_NONE;
        end
    end

    // decode of the write whose data phase is now
    always_comb begin
        if (!aphase_q.valid) begin
            wr_sel = SEL_NONE;
        end else if (aphase_q.addr == `EXT_REQ_FLAG_OFS) begin
            wr_sel = SEL_FLAG;
        end else if (aphase_q.addr == `EXT_REQ_MODE_OFS) begin
            wr_sel = SEL_MODE;
        end else if (aphase_q.addr == `EXT_REQ_EDGE_OFS) begin
            wr_sel = SEL_EDGE;
        end else begin
            wr_sel = SEL_NONE;
        end
    end

    assign rd_flag = take & ~hwrite & (rd_sel == SEL_FLAG);
    assign wr_flag = (wr_sel == SEL_FLAG);

    // detection setup registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode_q <= `EXT_REQ_MODE_RST;
        end else if (wr_sel == SEL_MODE) begin
            mode_q <= hwdata[LINES-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rising_q <= `EXT_REQ_EDGE_RST;
        end else if (wr_sel == SEL_EDGE) begin
            rising_q <= hwdata[LINES-1:0];
        end
    end

    // read data is loaded at the address phase and stands through the data phase
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata_q <= 32'h0000_0000;
            if (rd_sel == SEL_FLAG) begin
                hrdata_q[LINES-1:0] <= flag;
            end else if (rd_sel == SEL_MODE) begin
                hrdata_q[LINES-1:0] <= mode_q;
            end else if (rd_sel == SEL_EDGE) begin
                hrdata_q[LINES-1:0] <= rising_q;
            end else if (rd_sel == SEL_PIN) begin
                hrdata_q[LINES-1:0] <= pin_level;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            hreadyout_q <= 1'b1;
            hresp_q     <= `EXT_REQ_HRESP_OKAY;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= `EXT_REQ_HRESP_OKAY;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ext_req_out_q <= `EXT_REQ_FLAG_RST;
        end else begin
            ext_req_out_q <= flag;
        end
    end

    assign hrdata      = hrdata_q;
    assign hreadyout   = hreadyout_q;
    assign hresp       = hresp_q;
    assign ext_req_out = ext_req_out_q;

    genvar i;
    generate
        for (i = 0; i < LINES; i++) begin : g_line
            line_cfg_s line_cfg;

            assign accept_vec[i] = accept_valid & (accept_line == 3'(i));
            assign line_cfg      = {mode_q[i], rising_q[i]};

            ext_req_line u_line (
                .clock       (clock),
                .rstn        (rstn),
                .pin_async   (ext_req_pin[i]),
                .cfg         (line_cfg),
                .read_flag   (rd_flag),
                .write_flag  (wr_flag),
                .write_bit   (hwdata[i]),
                .accept      (accept_vec[i]),
                .flag_q      (flag[i]),
                .pin_level_q (pin_level[i])
            );
        end
    endgenerate

endmodule

`default_nettype wire

// ---- include/ext_req_defs.svh ----
// register offsets, field layouts and reset values of the external request flag block
// assumes a 32-bit AHB-Lite slave with one register per aligned word
`ifndef EXT_REQ_DEFS_SVH
`define EXT_REQ_DEFS_SVH

`define EXT_REQ_LINES         6
`define EXT_REQ_ADDR_W        8

// register byte offsets
`define EXT_REQ_FLAG_OFS      8'h00
`define EXT_REQ_MODE_OFS      8'h04
`define EXT_REQ_EDGE_OFS      8'h08
`define EXT_REQ_PIN_OFS       8'h0C

// reset values
`define EXT_REQ_FLAG_RST      6'h00
`define EXT_REQ_MODE_RST      6'h00
`define EXT_REQ_EDGE_RST      6'h00

// ahb encodings
`define EXT_REQ_HTRANS_NONSEQ 2'h2
`define EXT_REQ_HTRANS_SEQ    2'h3
`define EXT_REQ_HRESP_OKAY    1'h0

`endif

// ---- include/ext_req_pkg.sv ----
// types shared by the external request flag block and its per-line slice
// assumes ext_req_defs.svh on the include path
`include "ext_req_defs.svh"

package ext_req_pkg;

    // per-line detection setup
    typedef struct packed {
        logic edge_mode;   // 1: edge detection, 0: level detection
        logic rising;      // 1: rising edge, 0: falling edge
    } line_cfg_s;

    // captured ahb address phase
    typedef struct packed {
        logic                       valid;
        logic                       write;
        logic [`EXT_REQ_ADDR_W-1:0] addr;
    } ahb_aphase_s;

    // register selected by an address phase
    typedef enum logic [4:0] {
        SEL_NONE = 5'b0_0001,
        SEL_FLAG = 5'b0_0010,
        SEL_MODE = 5'b0_0100,
        SEL_EDGE = 5'b0_1000,
        SEL_PIN  = 5'b1_0000
    } reg_sel_e;

endpackage

// ---- src/ext_req_line.sv ----
// one external request line: pin synchroniser, edge detect and request flag
// assumes the pin is asynchronous; all other inputs come from the clock domain
`timescale 1ns/1ps
`default_nettype none

module ext_req_line
    import ext_req_pkg::*;
(
    input  wire logic      clock,        // system clock
    input  wire logic      rstn,         // synchronous reset, active low
    input  wire logic      pin_async,    // request pin, active low
    input  wire line_cfg_s cfg,          // detection setup
    input  wire logic      read_flag,    // flag register read this cycle
    input  wire logic      write_flag,   // flag register write this cycle
    input  wire logic      write_bit,    // written value of this flag
    input  wire logic      accept,       // processor accepts this line
    output logic           flag_q,       // request flag
    output logic           pin_level_q   // synchronised pin level
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic armed_q;
    logic edge_hit;
    logic sw_clear;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
        end else begin
            sync1_q <= pin_async;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign pin_level_q = sync2_q;

    assign edge_hit = cfg.rising ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);

    // a read arms the clear only if the flag was returned as 1
    always_ff @(posedge clock) begin
        if (!rstn) begin
            armed_q <= 1'b0;
        end else if (read_flag) begin
            armed_q <= flag_q;
        end else if (write_flag) begin
            armed_q <= 1'b0;
        end
    end

    assign sw_clear = write_flag & ~write_bit & armed_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else if (!cfg.edge_mode) begin
            flag_q <= ~sync2_q;
        end else if (edge_hit) begin
            flag_q <= 1'b1;
        end else if (accept || sw_clear) begin
            flag_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- tb/ext_req_assertions.sv ----
// port assertions for the external request flag block
// assumes a bind onto external_request_flags with hready fed from hreadyout
`timescale 1ns/1ps
`default_nettype none
module ext_req_assertions #(
    parameter int LINES = 6
)(
    input wire logic             clock,        // clock
    input wire logic             rstn,         // reset
    input wire logic [LINES-1:0] ext_req_pin,  // pins
    input wire logic             accept_valid, // accept
    input wire logic [2:0]       accept_line,  // line
    input wire logic [LINES-1:0] ext_req_out,  // flags
    input wire logic             hsel,         // select
    input wire logic [31:0]      haddr,        // address
    input wire logic [1:0]       htrans,       // type
    input wire logic             hwrite,       // write
    input wire logic             hready,       // ready in
    input wire logic [31:0]      hrdata,       // read data
    input wire logic             hreadyout,    // ready out
    input wire logic             hresp         // response
);
    wire             ap    = hsel & hready & htrans[1];
    wire [LINES-1:0] amask = accept_valid ? (LINES'(1) << accept_line) : '0;
    logic            wr_q;
    // flag write in its data phase
    always_ff @(posedge clock) wr_q <= rstn & ap & hwrite & (haddr == 32'h0);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_flag_rd;
        ap && !hwrite && haddr == 32'h0;
    endsequence
    sequence s_odd_rd;
        ap && !hwrite && haddr[7:4] != 4'h0;
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("ready out dropped");
    a_resp_okay: assert property (!hresp)
        else $error("response not okay");
    a_reset_zero: assert property ($rose(rstn) |-> ext_req_out == '0 && hrdata == 32'h0)
        else $error("outputs not clear after reset");
    a_read_mirror: assert property (s_flag_rd |=> hrdata == 32'(ext_req_out))
        else $error("flag read differs from flags");
    a_unmapped_zero: assert property (s_odd_rd |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_data_stands: assert property (!(ap && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_rise_cause: assert property (
        (ext_req_out & ~$past(ext_req_out) & $past(ext_req_pin, 4)
        & ~($past(ext_req_pin, 2) ^ $past(ext_req_pin, 7))) == '0)
        else $error("flag rose without pin cause");
    a_fall_cause: assert property (
        ($past(ext_req_out) & ~ext_req_out & ~($past(ext_req_pin, 4)
        | ($past(ext_req_pin, 2) ^ $past(ext_req_pin, 7)) | $past(amask) | $past(amask, 2)
        | {LINES{$past(wr_q) | $past(wr_q, 2)}})) == '0)
        else $error("flag fell without clear cause");
endmodule
`default_nettype wire

// ---- tb/ext_req_board.sv ----
// board logic driving the request pins
// assumes the bench sets the wanted levels
`timescale 1ns/1ps
`default_nettype none
module ext_req_board (
    input  wire logic       clock, // clock
    input  wire logic [5:0] want,  // wanted levels
    output logic      [5:0] pin    // pins, active low
);
    logic [5:0] level_q = 6'h3f;
    // pins move just after an edge
    always @(posedge clock) level_q <= want;
    assign pin = level_q;
endmodule
`default_nettype wire

// ---- tb/test_external_request_flags.sv ----
// self-checking bench for the external request flag block
// assumes design, checker and board model compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_external_request_flags;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        accept_valid = 1'b0;
    logic [2:0]  accept_line = 3'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [5:0]  want = 6'h3f;
    logic [5:0]  pins;
    logic [5:0]  eout;
    logic [5:0]  sel;
    logic [5:0]  m;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          seed = 28;
    int          k;
    always #12.5 clock = ~clock;
    external_request_flags DUT (.clock(clock), .rstn(rstn), .ext_req_pin(pins),
        .accept_valid(accept_valid), .accept_line(accept_line), .ext_req_out(eout),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    ext_req_board board (.clock(clock), .want(want), .pin(pins));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_out(input logic [5:0] g, input logic [5:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t request out %h want %h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rf(input logic [5:0] e);
        ahb(1'b0, 8'h00, 32'h0);
        chk(rd, {26'h0, e});
    endtask
    task automatic pin_set(input logic [5:0] v);
        @(posedge clock);
        want <= v;
        repeat (6) @(posedge clock);
    endtask
    task automatic acc(input int j);
        @(posedge clock);
        accept_valid <= 1'b1;
        accept_line <= 3'(j);
        @(posedge clock);
        accept_valid <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        ahb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        rf(6'h00);
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        for (k = 0; k < 4; k++) begin
            pin_set(6'($random(seed)));
            rf(~want);
            ahb(1'b1, 8'h00, 32'h0);
            rf(~want);
            acc(k);
            rf(~want);
            chk_out(eout, ~want);
            ahb(1'b0, 8'h0C, 32'h0);
            chk(rd, {26'h0, want});
        end
        $display("level test done");
        for (k = 0; k < 6; k++) begin
            sel = 6'($random(seed));
            m = 6'($random(seed));
            ahb(1'b1, 8'h04, 32'h0);
            pin_set(~sel);
            ahb(1'b1, 8'h08, {26'h0, sel});
            ahb(1'b1, 8'h04, 32'h0000_003f);
            ahb(1'b0, 8'h00, 32'h0);
            ahb(1'b1, 8'h00, 32'h0);
            rf(6'h00);
            pin_set(~sel ^ m);
            ahb(1'b1, 8'h00, 32'h0);
            rf(m);
            chk_out(eout, m);
            ahb(1'b1, 8'h00, 32'h0000_003f);
            rf(m);
            ahb(1'b1, 8'h00, 32'h0000_003f);
            ahb(1'b1, 8'h00, 32'h0);
            rf(m);
            acc(6 + k % 2);
            rf(m);
            acc(k);
            rf(m & ~(6'h01 << k));
            ahb(1'b1, 8'h00, 32'h0);
            rf(6'h00);
            pin_set(~sel);
            rf(6'h00);
        end
        $display("edge test done");
        end_of_test();
    end
endmodule
bind external_request_flags ext_req_assertions #(.LINES(LINES)) u_chk (.*);
`default_nettype wire
